// >>> verilog/dssr_top.v
// Dual serial shift register with shared clock and output buffers
// What this block does
// - Two independent 64-stage blocks, shift per rising edge, one held and others lost while the buffer is full
// - Select low takes input zero, high input one
// - True output last stage, complement beside it
// - Block A clocked by OR of A and shared
// - Block B clocked by OR of B and shared
`include "dssr_defines.vh"

// One shift block with its two-entry buffer of shifted-out bits
module dssr_lane #(
  parameter DEPTH = `DSSR_DEPTH
) (
  input wire clk,
  input wire rst_n,
  input wire shift_clk_s,
  input wire sel_s,
  input wire in_zero_s,
  input wire in_one_s,
  output wire true_out,
  output wire comp_out,
  output wire drop_valid,
  output wire drop_data,
  input wire drop_ready
);
  // Storage stages, index DEPTH-1 is the last stage
  reg [DEPTH-1:0] stage_reg;
  // Inverted copy of the last stage, kept in its own flop
  reg comp_reg;
  // Previous level of the effective clock
  reg clk_prev_reg;
  // Edge seen while the buffer was full
  reg pend_reg;
  // Buffer head and second entry
  reg head_d_reg;
  reg head_v_reg;
  reg tail_d_reg;
  reg tail_v_reg;
  // Combinational control of the lane
  wire edge_seen;
  wire buf_ready;
  wire do_shift;
  wire pop;
  wire new_bit;

  // Rising edge of the combined clock
  assign edge_seen = shift_clk_s & ~clk_prev_reg;
  // Buffer accepts a word unless both entries hold one
  assign buf_ready = ~tail_v_reg;
  // A shift waits while the buffer cannot take the bit that falls out
  // A pending shift takes the data pins as they stand when it runs
  assign do_shift = (edge_seen | pend_reg) & buf_ready;
  // Head leaves when the consumer takes it
  assign pop = head_v_reg & drop_ready;
  // Input choice by the select line
  assign new_bit = sel_s ? in_one_s : in_zero_s;

  // Every output is a flop, no gate after it
  assign true_out = stage_reg[DEPTH-1];
  assign comp_out = comp_reg;
  assign drop_valid = head_v_reg;
  assign drop_data = head_d_reg;

  // Edge tracking and pending shift
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'h0;
      pend_reg <= 1'h0;
    end else begin
      clk_prev_reg <= shift_clk_s;
      // A new edge wins over the clear of the pending one
      // An edge while one waits stays queued if the buffer frees now
      // An edge while one waits and the buffer is still full is lost
      if (edge_seen && (!buf_ready || pend_reg)) begin
        pend_reg <= 1'h1;
      end else if (do_shift) begin
        pend_reg <= 1'h0;
      end
    end
  end

  // Shift chain, one stage per effective edge, except an edge lost on a full buffer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= {DEPTH{`DSSR_STAGE_RST}};
      comp_reg <= ~`DSSR_STAGE_RST;
    end else if (do_shift) begin
      // Bit entered now is last stage after DEPTH shifts
      stage_reg <= {stage_reg[DEPTH-2:0], new_bit};
      comp_reg <= ~stage_reg[DEPTH-2];
    end
  end

  // Two-entry buffer of bits leaving the last stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_d_reg <= `DSSR_BUF_RST;
      head_v_reg <= 1'h0;
      tail_d_reg <= `DSSR_BUF_RST;
      tail_v_reg <= 1'h0;
    end else begin
      case ({do_shift, pop})
        2'h2: begin
          // Push only
          if (!head_v_reg) begin
            head_d_reg <= stage_reg[DEPTH-1];
            head_v_reg <= 1'h1;
          end else begin
            tail_d_reg <= stage_reg[DEPTH-1];
            tail_v_reg <= 1'h1;
          end
        end
        2'h1: begin
          // Pop only, tail moves up
          head_d_reg <= tail_d_reg;
          head_v_reg <= tail_v_reg;
          tail_v_reg <= 1'h0;
        end
        2'h3: begin
          // Pop and push together, tail empty by buf_ready
          head_d_reg <= stage_reg[DEPTH-1];
          head_v_reg <= 1'h1;
        end
        default: begin
          // Idle
          head_v_reg <= head_v_reg;
        end
      endcase
    end
  end
endmodule

// Top level: pin synchroniser, clock combining and two blocks
module dssr_top #(
  parameter DEPTH = `DSSR_DEPTH
) (
  input wire clk,
  input wire rst_n,
  input wire clk_a,
  input wire clk_b,
  input wire clk_c,
  input wire sel_a,
  input wire sel_b,
  input wire in_zero_a,
  input wire in_one_a,
  input wire in_zero_b,
  input wire in_one_b,
  output wire true_out_a,
  output wire comp_out_a,
  output wire true_out_b,
  output wire comp_out_b,
  output wire drop_valid_a,
  output wire drop_data_a,
  input wire drop_ready_a,
  output wire drop_valid_b,
  output wire drop_data_b,
  input wire drop_ready_b
);
  // Two-flop synchroniser for all pin inputs except drop_ready_a and drop_ready_b
  reg [`DSSR_SYNC_W-1:0] sync1_reg;
  reg [`DSSR_SYNC_W-1:0] sync2_reg;
  wire [`DSSR_SYNC_W-1:0] pins;
  // Combined shift clocks of the blocks
  wire eff_clk_a;
  wire eff_clk_b;

  // Pin vector in synchroniser bit order
  assign pins = {in_one_b, in_zero_b, in_one_a, in_zero_a, sel_b, sel_a, clk_c, clk_b, clk_a};

  // Synchroniser stages; only sync2 is read by logic
  // Cleared to zero so a low pin gives no false edge after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= {`DSSR_SYNC_W{1'h0}};
      sync2_reg <= {`DSSR_SYNC_W{1'h0}};
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Effective clocks of the two blocks
  // OR taken after the synchroniser so clock and data share latency
  // Pin clocks must stay high and low one cycle each to be seen
  assign eff_clk_a = sync2_reg[`DSSR_POS_CLK_A] | sync2_reg[`DSSR_POS_CLK_C];
  assign eff_clk_b = sync2_reg[`DSSR_POS_CLK_B] | sync2_reg[`DSSR_POS_CLK_C];

  // Block A
  dssr_lane #(
    .DEPTH(DEPTH)
  ) u_lane_a (
    .clk(clk),
    .rst_n(rst_n),
    .shift_clk_s(eff_clk_a),
    .sel_s(sync2_reg[`DSSR_POS_SEL_A]),
    .in_zero_s(sync2_reg[`DSSR_POS_IN0_A]),
    .in_one_s(sync2_reg[`DSSR_POS_IN1_A]),
    .true_out(true_out_a),
    .comp_out(comp_out_a),
    .drop_valid(drop_valid_a),
    .drop_data(drop_data_a),
    .drop_ready(drop_ready_a)
  );

  // Block B
  dssr_lane #(
    .DEPTH(DEPTH)
  ) u_lane_b (
    .clk(clk),
    .rst_n(rst_n),
    .shift_clk_s(eff_clk_b),
    .sel_s(sync2_reg[`DSSR_POS_SEL_B]),
    .in_zero_s(sync2_reg[`DSSR_POS_IN0_B]),
    .in_one_s(sync2_reg[`DSSR_POS_IN1_B]),
    .true_out(true_out_b),
    .comp_out(comp_out_b),
    .drop_valid(drop_valid_b),
    .drop_data(drop_data_b),
    .drop_ready(drop_ready_b)
  );
endmodule

// >>> verilog/dssr_defines.vh
// Constants for the dual serial shift register
`ifndef DSSR_DEFINES_VH
`define DSSR_DEFINES_VH
// Stages in each shift block
`define DSSR_DEPTH 64
// Reset value of every storage stage
`define DSSR_STAGE_RST 1'h0
// Reset value of the two-entry output buffer
`define DSSR_BUF_RST 1'h0
// Pin inputs passed through the synchroniser
`define DSSR_SYNC_W 9
// Positions in the synchroniser vector
`define DSSR_POS_CLK_A 0
`define DSSR_POS_CLK_B 1
`define DSSR_POS_CLK_C 2
`define DSSR_POS_SEL_A 3
`define DSSR_POS_SEL_B 4
`define DSSR_POS_IN0_A 5
`define DSSR_POS_IN1_A 6
`define DSSR_POS_IN0_B 7
`define DSSR_POS_IN1_B 8
`endif

// >>> verification/dssr_src.sv
// Far-side driver of the three shift clock pins
module dssr_src (
  input wire clk,
  output logic clk_a = 1'h0,
  output logic clk_b = 1'h0,
  output logic clk_c = 1'h0
);
  timeunit 1ns / 1ns;
  // One edge: high then low for 3 cycles each
  task pulse(input logic [2:0] m);
    {clk_c, clk_b, clk_a} <= m;
    repeat (3) @(posedge clk);
    {clk_c, clk_b, clk_a} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// >>> verification/dssr_top_chk.sv
// Assertions on the dual serial shift register ports
module dssr_chk (
  input wire clk,
  input wire rst_n,
  input wire clk_a,
  input wire clk_b,
  input wire clk_c,
  input wire true_out_a,
  input wire comp_out_a,
  input wire true_out_b,
  input wire comp_out_b,
  input wire drop_valid_a,
  input wire drop_valid_b,
  input wire drop_ready_b
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Lone clock edge into an empty buffer
  sequence up_a; $rose(clk_a) && !clk_c && !drop_valid_a; endsequence
  sequence up_b; $rose(clk_b) && !clk_c && !drop_valid_b; endsequence
  inv_a_a: assert property (comp_out_a == !true_out_a) else $error("comp a");
  inv_b_a: assert property (comp_out_b == !true_out_b) else $error("comp b");
  shift_a_a: assert property (up_a |-> ##[2:4] drop_valid_a) else $error("shift a");
  shift_b_a: assert property (up_b |-> ##[2:4] drop_valid_b) else $error("shift b");
  held_b_a: assert property (drop_valid_b && !drop_ready_b |=> drop_valid_b)
    else $error("held b");
  still_a_a: assert property ((!clk_a && !clk_c && !drop_valid_a) [*4] |=>
    $stable(true_out_a)) else $error("still a");
endmodule
bind dssr_top dssr_chk u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .clk_a(clk_a),
  .clk_b(clk_b),
  .clk_c(clk_c),
  .true_out_a(true_out_a),
  .comp_out_a(comp_out_a),
  .true_out_b(true_out_b),
  .comp_out_b(comp_out_b),
  .drop_valid_a(drop_valid_a),
  .drop_valid_b(drop_valid_b),
  .drop_ready_b(drop_ready_b)
);

// >>> verification/dual_serial_shift_register_tb.sv
// Self-checking bench for the dual serial shift register
module dual_serial_shift_register_tb;
  timeunit 1ns / 1ns;
  localparam int D = 4;
  localparam logic [7:0] P = 8'hB4;
  logic clk = 1'h0, rst_n = 1'h0, sel_a = 1'h0, sel_b = 1'h0, in_zero_a = 1'h0;
  logic in_zero_b = 1'h0, drop_ready_a = 1'h1, drop_ready_b = 1'h1;
  wire clk_a, clk_b, clk_c, true_out_a, comp_out_a, true_out_b, comp_out_b;
  wire drop_valid_a, drop_data_a, drop_valid_b, drop_data_b;
  wire in_one_a = true_out_a;
  wire in_one_b = true_out_a;
  int err_total = 0;
  int compares = 0;
  dssr_src src (
    .clk(clk),
    .clk_a(clk_a),
    .clk_b(clk_b),
    .clk_c(clk_c)
  );
  dssr_top #(.DEPTH(D)) DUT (
    .clk(clk),
    .rst_n(rst_n),
    .clk_a(clk_a),
    .clk_b(clk_b),
    .clk_c(clk_c),
    .sel_a(sel_a),
    .sel_b(sel_b),
    .in_zero_a(in_zero_a),
    .in_one_a(in_one_a),
    .in_zero_b(in_zero_b),
    .in_one_b(in_one_b),
    .true_out_a(true_out_a),
    .comp_out_a(comp_out_a),
    .true_out_b(true_out_b),
    .comp_out_b(comp_out_b),
    .drop_valid_a(drop_valid_a),
    .drop_data_a(drop_data_a),
    .drop_ready_a(drop_ready_a),
    .drop_valid_b(drop_valid_b),
    .drop_data_b(drop_data_b),
    .drop_ready_b(drop_ready_b)
  );
  task chk(input string n, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %b got %b", n, e, s);
    end
  endtask
  task wrap_up;
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Pattern in through input zero
  task t_delay;
    for (int i = 0; i < 2 * D; i++) begin
      in_zero_a <= P[i];
      drop_ready_a <= i[0];
      src.pulse(3'h1);
      if (i >= D - 1) chk("true_out_a", P[i - D + 1], true_out_a);
      if (!i[0]) begin
        chk("drop_valid_a", 1'h1, drop_valid_a);
        chk("drop_data_a", i >= D ? P[i - D] : 1'h0, drop_data_a);
      end
    end
  endtask
  // A loops back, B fills on the shared clock
  task t_recirc;
    sel_a <= 1'h1;
    in_zero_b <= 1'h1;
    for (int j = 0; j < D; j++) begin
      src.pulse(3'h4);
      chk("true_out_a", P[D + (j + 1) % D], true_out_a);
    end
    chk("true_out_b", 1'h1, true_out_b);
  endtask
  // Buffer full, third edge waits
  task t_stall;
    int n;
    n = 0;
    drop_ready_b <= 1'h0;
    in_zero_b <= 1'h0;
    repeat (3) src.pulse(3'h2);
    drop_ready_b <= 1'h1;
    repeat (20) @(negedge clk) begin
      n += drop_valid_b;
      if (drop_valid_b === 1'h1) chk("drop_data_b", 1'h1, drop_data_b);
    end
    chk("pops_b", 1'h1, n == 3);
    @(posedge clk);
    src.pulse(3'h2);
    chk("true_out_b", 1'h0, true_out_b);
  endtask
  // B chained behind A, both on the shared clock
  task t_chain;
    sel_b <= 1'h1;
    for (int j = 0; j < 2 * D; j++) begin
      src.pulse(3'h4);
      if (j >= D - 1) begin
        chk("true_out_b", P[D + (j + 1) % D], true_out_b);
        chk("comp_out_b", ~P[D + (j + 1) % D], comp_out_b);
      end
    end
  endtask
  // Output levels straight after reset
  task t_idle;
    chk("true_out_a", 1'h0, true_out_a);
    chk("comp_out_a", 1'h1, comp_out_a);
    chk("true_out_b", 1'h0, true_out_b);
    chk("comp_out_b", 1'h1, comp_out_b);
    chk("drop_valid_a", 1'h0, drop_valid_a);
    chk("drop_valid_b", 1'h0, drop_valid_b);
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_idle;
    t_delay;
    t_recirc;
    t_stall;
    t_chain;
    wrap_up;
  end
endmodule
